/* hw/gcsa_acceptor.sv */
// Instrument-side acceptor of bus command sequences and device-dependent strings.
`timescale 1ns/1ps
module gcsa_acceptor
   import gcsa_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Bus pins, levels as true logic (1 = asserted).
   input  wire logic [7:0] bus_dio_in,
   input  wire logic       bus_atn_in,
   input  wire logic       bus_dav_in,
   output logic            bus_nrfd_out,
   output logic            bus_nrfd_oe,
   output logic            bus_ndac_out,
   output logic            bus_ndac_oe,
   // Talker data path.
   input  wire logic [7:0] talk_data,
   output logic [7:0]      bus_dio_out,
   output logic            bus_dio_oe,
   // Primary address programming.
   input  wire logic [4:0] addr_wr_data,
   input  wire logic       addr_wr_en,
   // Device status.
   output logic [4:0]      primary_addr,
   output logic            listen_active,
   output logic            talk_active,
   output logic            lockout_active,
   output logic            clear_pulse,
   output logic [3:0]      func_sel,
   output logic            func_pulse
);
   logic [9:0]  sync_w;
   logic [7:0]  dio_s;
   logic        atn_s;
   logic        dav_s;

   // All bus inputs cross into the clock domain through two flops.
   gcsa_sync #(.WIDTH(10)) u_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .din     ({bus_dio_in, bus_atn_in, bus_dav_in}),
      .dout    (sync_w)
   );
   assign dio_s = sync_w[9:2];
   assign atn_s = sync_w[1];
   assign dav_s = sync_w[0];

   gcsa_hs_t    hs_r,   hs_nxt;
   gcsa_dds_t   dds_r,  dds_nxt;
   logic [7:0]  byte_r, byte_nxt;
   logic        batn_r, batn_nxt;
   logic        take;
   logic [4:0]  pa_r,   pa_nxt;
   logic        lsn_r,  lsn_nxt;
   logic        tlk_r,  tlk_nxt;
   logic        llo_r,  llo_nxt;
   logic        clr_r,  clr_nxt;
   logic [3:0]  fn_r,   fn_nxt;
   logic        fnp_r,  fnp_nxt;
   logic [7:0]  do_r,   do_nxt;
   logic [7:0]  my_lag;
   logic [7:0]  my_tag;
   logic        is_cmd;
   logic        is_data;

   // Handshake: latch byte on data valid, then release not-accepted until valid drops.
   always_comb
   begin
      hs_nxt   = hs_r;
      byte_nxt = byte_r;
      batn_nxt = batn_r;
      take     = 1'b0;
      case (hs_r)
         GCSA_HS_READY:
            if (dav_s)
            begin
               byte_nxt = dio_s;
               batn_nxt = atn_s;
               hs_nxt   = GCSA_HS_LATCH;
            end
         GCSA_HS_LATCH:
         begin
            take   = 1'b1;
            hs_nxt = GCSA_HS_DONE;
         end
         GCSA_HS_DONE:
            if (!dav_s)
               hs_nxt = GCSA_HS_READY;
         default:
            hs_nxt = GCSA_HS_READY;
      endcase
   end

   // Not-ready is held except when idle; not-accepted held until the cycle after the byte is latched.
   assign bus_nrfd_out = 1'b1;
   assign bus_nrfd_oe  = (hs_r != GCSA_HS_READY);
   assign bus_ndac_out = 1'b1;
   assign bus_ndac_oe  = (hs_r != GCSA_HS_DONE);

   assign my_lag  = GCSA_LAG_BASE | {3'b000, pa_r};
   assign my_tag  = GCSA_TAG_BASE | {3'b000, pa_r};
   assign is_cmd  = take && batn_r;
   assign is_data = take && !batn_r;

   // Command decoding, address programming and device string parsing.
   always_comb
   begin
      pa_nxt  = pa_r;
      lsn_nxt = lsn_r;
      tlk_nxt = tlk_r;
      llo_nxt = llo_r;
      clr_nxt = 1'b0;
      fn_nxt  = fn_r;
      fnp_nxt = 1'b0;
      dds_nxt = dds_r;
      do_nxt  = tlk_r ? talk_data : do_r;
      if (addr_wr_en && addr_wr_data <= GCSA_ADDR_MAX)
         pa_nxt = addr_wr_data;
      if (is_cmd)
      begin
         dds_nxt = GCSA_DDS_IDLE;
         if (byte_r[6:0] == GCSA_UNL_BYTE[6:0])
            lsn_nxt = 1'b0;
         else if (byte_r[6:0] == my_lag[6:0])
            lsn_nxt = 1'b1;
         if (byte_r[6:0] == GCSA_UNT_BYTE[6:0])
            tlk_nxt = 1'b0;
         else if (byte_r[6:0] == my_tag[6:0])
         begin
            tlk_nxt = 1'b1;
            lsn_nxt = 1'b0;
         end
         else if (byte_r[6:5] == GCSA_TAG_BASE[6:5])
            tlk_nxt = 1'b0;
         if (byte_r[6:0] == GCSA_LLO_BYTE[6:0])
            llo_nxt = 1'b1;
         if (byte_r[6:0] == GCSA_DCL_BYTE[6:0])
         begin
            clr_nxt = 1'b1;
            fn_nxt  = GCSA_FUNC_RESET;
         end
         if (byte_r[6:0] == GCSA_SDC_BYTE[6:0] && lsn_r)
         begin
            clr_nxt = 1'b1;
            fn_nxt  = GCSA_FUNC_RESET;
         end
         if (byte_r[6:0] == GCSA_GTL_BYTE[6:0] && lsn_r)
            llo_nxt = 1'b0;
      end
      else if (is_data && lsn_r)
      begin
         case (dds_r)
            GCSA_DDS_IDLE:
               if (byte_r == GCSA_FUNC_CHAR)
                  dds_nxt = GCSA_DDS_FUNC;
            GCSA_DDS_FUNC:
               dds_nxt = (byte_r == GCSA_ZERO_CHAR) ? GCSA_DDS_DIGIT : GCSA_DDS_IDLE;
            GCSA_DDS_DIGIT:
            begin
               dds_nxt = GCSA_DDS_IDLE;
               if (byte_r == GCSA_EXEC_CHAR)
               begin
                  fn_nxt  = GCSA_FUNC_DCV;
                  fnp_nxt = 1'b1;
               end
            end
            default:
               dds_nxt = GCSA_DDS_IDLE;
         endcase
      end
   end

   // State registers.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hs_r   <= GCSA_HS_READY;
         byte_r <= 8'h00;
         batn_r <= 1'b0;
         pa_r   <= GCSA_ADDR_RESET;
         lsn_r  <= 1'b0;
         tlk_r  <= 1'b0;
         llo_r  <= 1'b0;
         clr_r  <= 1'b0;
         fn_r   <= GCSA_FUNC_RESET;
         fnp_r  <= 1'b0;
         dds_r  <= GCSA_DDS_IDLE;
         do_r   <= 8'h00;
      end
      else
      begin
         hs_r   <= hs_nxt;
         byte_r <= byte_nxt;
         batn_r <= batn_nxt;
         pa_r   <= pa_nxt;
         lsn_r  <= lsn_nxt;
         tlk_r  <= tlk_nxt;
         llo_r  <= llo_nxt;
         clr_r  <= clr_nxt;
         fn_r   <= fn_nxt;
         fnp_r  <= fnp_nxt;
         dds_r  <= dds_nxt;
         do_r   <= do_nxt;
      end
   end

   // Outputs; data lines driven only while talking and attention is low.
   assign bus_dio_out    = do_r;
   assign bus_dio_oe     = tlk_r && !atn_s;
   assign primary_addr   = pa_r;
   assign listen_active  = lsn_r;
   assign talk_active    = tlk_r;
   assign lockout_active = llo_r;
   assign clear_pulse    = clr_r;
   assign func_sel       = fn_r;
   assign func_pulse     = fnp_r;

   // Checks.
   chk_unl_leaves: assert property (@(posedge clk_sys) disable iff (!rst_b)
      is_cmd && byte_r == GCSA_UNL_BYTE |=> !lsn_r) else $error("unlisten did not clear listener");
   chk_lag_enters: assert property (@(posedge clk_sys) disable iff (!rst_b)
      is_cmd && byte_r == my_lag |=> lsn_r) else $error("own listen address not taken");
   chk_lag_value: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pa_r == GCSA_ADDR_RESET |-> my_lag == 8'h2A) else $error("listen address wrong for address 10");
   chk_sdc_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
      is_cmd && byte_r == GCSA_SDC_BYTE |=> clr_r == $past(lsn_r)) else $error("selected clear gating wrong");
   chk_dcl_univ: assert property (@(posedge clk_sys) disable iff (!rst_b)
      is_cmd && byte_r == GCSA_DCL_BYTE |=> clr_r) else $error("universal clear ignored");
   chk_llo_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      is_cmd && byte_r == GCSA_LLO_BYTE |=> llo_r) else $error("lockout not recognised");
   chk_data_ignored: assert property (@(posedge clk_sys) disable iff (!rst_b)
      is_data && !lsn_r |=> $stable(fn_r) && !fnp_r) else $error("unaddressed data changed setting");
   chk_talk_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus_dio_oe |-> tlk_r) else $error("data driven while not talker");
   chk_ndac_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(dav_s) && hs_r == GCSA_HS_READY |-> bus_ndac_oe ##1 bus_ndac_oe ##1 !bus_ndac_oe)
      else $error("not-accepted released before latch");
   chk_addr_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pa_r <= GCSA_ADDR_MAX) else $error("primary address out of range");
endmodule : gcsa_acceptor

/* hw/gcsa_pkg.sv */
// Package with bus command codes, address groups and handshake constants for the command acceptor.
package gcsa_pkg;
   localparam logic [7:0] GCSA_UNL_BYTE      = 8'h3F;
   localparam logic [7:0] GCSA_UNT_BYTE      = 8'h5F;
   localparam logic [7:0] GCSA_LAG_BASE      = 8'h20;
   localparam logic [7:0] GCSA_TAG_BASE      = 8'h40;
   localparam logic [7:0] GCSA_SDC_BYTE      = 8'h04;
   localparam logic [7:0] GCSA_DCL_BYTE      = 8'h14;
   localparam logic [7:0] GCSA_LLO_BYTE      = 8'h11;
   localparam logic [7:0] GCSA_GTL_BYTE      = 8'h01;
   localparam logic [7:0] GCSA_FUNC_CHAR     = 8'h46;
   localparam logic [7:0] GCSA_ZERO_CHAR     = 8'h30;
   localparam logic [7:0] GCSA_EXEC_CHAR     = 8'h58;
   localparam logic [4:0] GCSA_ADDR_RESET    = 5'h0A;
   localparam logic [4:0] GCSA_ADDR_MAX      = 5'h1E;
   localparam logic [6:0] GCSA_CMD_MASK      = 7'h7F;
   localparam logic [3:0] GCSA_FUNC_DCV      = 4'h0;
   localparam logic [3:0] GCSA_FUNC_RESET    = 4'h0;
   localparam int         GCSA_SYNC_STAGES   = 2;
   typedef enum logic [1:0] {GCSA_DDS_IDLE, GCSA_DDS_FUNC, GCSA_DDS_DIGIT} gcsa_dds_t;
   typedef enum logic [1:0] {GCSA_HS_READY, GCSA_HS_LATCH, GCSA_HS_DONE} gcsa_hs_t;
endpackage : gcsa_pkg

/* hw/gcsa_sync.sv */
// Two-flop synchroniser for a bundle of bus input pins.
`timescale 1ns/1ps
module gcsa_sync
   import gcsa_pkg::*;
#(
   parameter int WIDTH = 11
)(
   // Clock and reset.
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Raw and synchronised levels.
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   // The first stage feeds only the second stage.
   always_comb
   begin
      meta_nxt = din;
      sync_nxt = meta_r;
   end

   // Both stages reset to zero.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         sync_r <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign dout = sync_r;
endmodule : gcsa_sync

/* testbench/gcsa_ctl_model.sv */
// Behavioural bus controller that sends one byte per request over the three-wire handshake.
`timescale 1ns/1ps
module gcsa_ctl_model
(
   // Clock.
   input  wire logic       clk_sys,
   // Request from the bench.
   input  wire logic       go,
   input  wire logic [7:0] byte_in,
   input  wire logic [1:0] slow,
   output logic            done,
   // Bus side, true logic levels.
   output logic [7:0]      dio,
   output logic            dav,
   input  wire logic       nrfd_asserted,
   input  wire logic       ndac_asserted
);
   int n;

   // Idle bus at time zero.
   initial
   begin
      dio  = 8'hFF;
      dav  = 1'b0;
      done = 1'b0;
   end

   // Places the byte after attention is set, then runs one handshake; a released bus shows the inverse byte.
   always @(posedge clk_sys)
   begin
      if (go)
      begin
         @(negedge clk_sys);
         dio = byte_in;
         repeat (slow + 1) @(negedge clk_sys);
         for (n = 0; n < 100 && nrfd_asserted; n++) @(negedge clk_sys);
         dav = 1'b1;
         for (n = 0; n < 100 && ndac_asserted; n++) @(negedge clk_sys);
         dav = 1'b0;
         dio = ~dio;
         for (n = 0; n < 100 && !ndac_asserted; n++) @(negedge clk_sys);
         done = 1'b1;
         @(negedge clk_sys);
         done = 1'b0;
      end
   end
endmodule : gcsa_ctl_model

/* testbench/test_gcsa_acceptor.sv */
// Self-checking bench for the command sequence acceptor, driven through the controller model.
`timescale 1ns/1ps
module test_gcsa_acceptor
   import gcsa_pkg::*;
;
   logic       clk_sys, rst_b, ctl_atn, go, done, dav, addr_wr_en, nrfd_oe, ndac_oe, dio_oe;
   logic       listen_active, talk_active, lockout_active, clear_pulse, func_pulse;
   logic       nrfd_out, ndac_out;
   logic [7:0] ctl_byte, dio, talk_data, dio_out;
   logic [4:0] addr_wr_data, primary_addr;
   logic [3:0] func_sel;
   logic [1:0] slow;
   int         err_count = 0, check_count = 0, cycles = 0, clr_cnt = 0, fn_cnt = 0;

   gcsa_ctl_model gcsa_ctl_model_inst (.clk_sys(clk_sys), .go(go), .byte_in(ctl_byte), .slow(slow),
      .done(done), .dio(dio), .dav(dav), .nrfd_asserted(nrfd_oe), .ndac_asserted(ndac_oe));

   gcsa_acceptor gcsa_acceptor_inst (.clk_sys(clk_sys), .rst_b(rst_b), .bus_dio_in(dio), .bus_atn_in(ctl_atn),
      .bus_dav_in(dav), .bus_nrfd_out(nrfd_out), .bus_nrfd_oe(nrfd_oe), .bus_ndac_out(ndac_out),
      .bus_ndac_oe(ndac_oe),
      .talk_data(talk_data), .bus_dio_out(dio_out), .bus_dio_oe(dio_oe), .addr_wr_data(addr_wr_data),
      .addr_wr_en(addr_wr_en), .primary_addr(primary_addr), .listen_active(listen_active),
      .talk_active(talk_active), .lockout_active(lockout_active), .clear_pulse(clear_pulse),
      .func_sel(func_sel), .func_pulse(func_pulse));

   // Clock generator.
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Expected listen and talk address bytes.
   function automatic logic [7:0] lag(input logic [4:0] a);
      return GCSA_LAG_BASE | {3'h0, a};
   endfunction : lag

   function automatic logic [7:0] tlk(input logic [4:0] a);
      return GCSA_TAG_BASE | {3'h0, a};
   endfunction : tlk

   // Ends the run with the counts and the verdict.
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // Counts pulses and cuts a hang short.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (clear_pulse === 1'b1) clr_cnt++;
      if (func_pulse === 1'b1) fn_cnt++;
      if (cycles == 20000)
      begin
         err_count++;
         print_verdict();
      end
   end

   // Compares one value and reports a mismatch.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   // Sends one byte; attention is set two cycles before the byte goes out.
   task automatic send(input logic a, input logic [7:0] b);
      int n;
      @(negedge clk_sys);
      ctl_atn  = a;
      ctl_byte = b;
      slow     = 2'($urandom_range(0, 3));
      @(negedge clk_sys);
      go = 1'b1;
      for (n = 0; n < 200 && done !== 1'b1; n++) @(posedge clk_sys);
      if (n >= 200) err_count++;
      @(negedge clk_sys);
      go = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask : send

   // Sends the DC volts selection string as device data.
   task automatic send_dc_volts_string;
      send(1'b0, GCSA_FUNC_CHAR);
      send(1'b0, GCSA_ZERO_CHAR);
      send(1'b0, GCSA_EXEC_CHAR);
   endtask : send_dc_volts_string

   // Programs the primary address with a one-cycle strobe.
   task automatic wr_addr(input logic [4:0] d);
      @(negedge clk_sys);
      addr_wr_data = d;
      addr_wr_en   = 1'b1;
      @(negedge clk_sys);
      addr_wr_en   = 1'b0;
   endtask : wr_addr

   // Main sequence.
   initial
   begin
      int c, f, a;
      rst_b = 1'b0; ctl_atn = 1'b0; go = 1'b0; ctl_byte = 8'h00; slow = 2'h0;
      addr_wr_en = 1'b0; addr_wr_data = 5'h00; talk_data = 8'h00;
      void'($urandom(14));
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      chk({3'h0, primary_addr}, {3'h0, GCSA_ADDR_RESET});
      chk({6'h0, nrfd_oe, ndac_oe}, 8'h01);
      chk({6'h0, nrfd_out, ndac_out}, 8'h03);
      $display("test reset done");
      send(1'b1, GCSA_LLO_BYTE);
      chk({7'h0, lockout_active}, 8'h01);
      c = clr_cnt;
      send(1'b1, GCSA_DCL_BYTE);
      chk(8'(clr_cnt - c), 8'h01);
      send(1'b1, GCSA_SDC_BYTE);
      chk(8'(clr_cnt - c), 8'h01);
      send(1'b1, GCSA_GTL_BYTE);
      chk({7'h0, lockout_active}, 8'h01);
      f = fn_cnt;
      send_dc_volts_string();
      chk(8'(fn_cnt - f), 8'h00);
      $display("test unaddressed done");
      send(1'b1, GCSA_UNL_BYTE);
      send(1'b1, 8'h2A);
      chk({7'h0, listen_active}, 8'h01);
      send(1'b1, GCSA_SDC_BYTE);
      chk(8'(clr_cnt - c), 8'h02);
      send_dc_volts_string();
      chk(8'(fn_cnt - f), 8'h01);
      chk({4'h0, func_sel}, {4'h0, GCSA_FUNC_DCV});
      send(1'b1, GCSA_GTL_BYTE);
      chk({7'h0, lockout_active}, 8'h00);
      send(1'b0, GCSA_UNL_BYTE);
      chk({7'h0, listen_active}, 8'h01);
      send(1'b1, GCSA_UNL_BYTE);
      chk({7'h0, listen_active}, 8'h00);
      $display("test addressed done");
      for (int i = 0; i < 6; i++)
      begin
         a = (i == 0) ? 0 : (i == 1) ? 30 : $urandom_range(0, 30);
         wr_addr(5'(a));
         wr_addr(5'h1F);
         chk({3'h0, primary_addr}, 8'(a));
         send(1'b1, lag(5'((a + 1) % 31)));
         chk({7'h0, listen_active}, 8'h00);
         send(1'b1, lag(5'(a)));
         chk({7'h0, listen_active}, 8'h01);
         send(1'b1, tlk(5'(a)));
         chk({7'h0, talk_active}, 8'h01);
         @(negedge clk_sys);
         talk_data = 8'($urandom);
         ctl_atn   = 1'b0;
         repeat (5) @(negedge clk_sys);
         chk({7'h0, dio_oe}, 8'h01);
         chk(dio_out, talk_data);
         send(1'b1, GCSA_UNT_BYTE);
         chk({7'h0, talk_active}, 8'h00);
      end
      $display("test addresses done");
      print_verdict();
   end
endmodule : test_gcsa_acceptor
